//--- rtl/psmc_pkg.sv
// Shared constants and types of the power save mode controller
package psmc_pkg;

  // ==========================================================
  // Register map, byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_WAKE   = 8'h04;
  localparam logic [7:0] ADDR_CTXA   = 8'h08;
  localparam logic [7:0] ADDR_CTXB   = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ==========================================================
  // Control register fields
  localparam int CTRL_DEEP_SLEEP_ENABLE_BIT_BIT    = 15;
  localparam int CTRL_BOR_BIT     = 1;
  localparam int CTRL_RELEASE_BIT = 0;

  // ==========================================================
  // Entry window in instruction cycles
  localparam logic [1:0] DEEP_SLEEP_ENABLE_BIT_WINDOW = 2'h3;

  // ==========================================================
  // Operand code of light sleep; any other value means idle
  localparam logic [7:0] OP_SLEEP = 8'h00;

  // ==========================================================
  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_IDLE  = 2'b10,
    MODE_DEEP  = 2'b11
  } psmc_mode_t;

  // ==========================================================
  // Deep sleep wake sources, also the wake status layout
  typedef struct packed {
    logic deep_sleep_watchdog;
    logic external_interrupt_zero;
    logic calendar_clock;
    logic master_clear_reset;
    logic por;
  } psmc_wake_t;

  localparam int WAKE_W = 5;

  // ==========================================================
  // Clock and power enables driven to the chip
  typedef struct packed {
    logic sys_clk;
    logic osc;
    logic cpu_clk;
    logic periph_clk;
    logic low_power_rc_oscillator;
    logic clock_failure_monitor;
    logic mem_pwr;
    logic calendar_clock_run;
    logic deep_sleep_watchdog_run;
    logic deep_sleep_brownout_reset_run;
  } psmc_pwr_t;

endpackage : psmc_pkg

//--- rtl/psmc_top.sv
// Power save mode controller with Wishbone register access
// ==========================================================
// Overview of operation
// - Light sleep stops system clock, on-chip oscillator and code execution.
// - Idle halts the CPU while peripherals keep their system clock.
// - Deep sleep keeps only calendar, its watchdog and brown-out, freezes pins, drops memory.
// - Enabled interrupt, any reset or watchdog time-out ends sleep or idle.
// - Light sleep freezes pin direction and output; clock monitor is off.
// - Light sleep keeps RC oscillator if watchdog or RC-fed calendar enabled.
// - Enabled watchdog is cleared just before light sleep entry.
// - Light sleep disables system-clocked peripherals; change notify may run.
// - Wake from light sleep resumes the clock source used at entry.
// - Entering idle clears the watchdog count.
// - Idle keeps RC oscillator if watchdog or clock monitor enabled.
// - Idle wake restores CPU clock and resumes execution at once.
// - Interrupt during the instruction waits for entry, then wakes at once.
// - Deep sleep ends on power-on, master clear, alarm, pin interrupt, watchdog.
// - Calendar clock keeps counting through deep sleep.
// - Dedicated deep sleep brown-out and watchdog, separate from normal ones.
// - Deep sleep only if sleep instruction follows enable within three cycles.
// - Late instruction makes hardware clear the enable bit.
// - Enable bit clears on every deep sleep exit.
// - Setting the enable bit clears all wake status bits.
// - Deep sleep wake performs a full power-on reset to the reset vector.
// - Pending interrupts are discarded on deep sleep entry.
// - Pins stay frozen after deep sleep wake until software clears release bit 0.
//
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/100ps

module psmc_top #(
  parameter int PIN_W = 16,
  parameter int OSC_W = 3
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Processor core
  input  wire logic               instr_cycle_i,
  input  wire logic               pwrsav_i,
  input  wire logic [7:0]         pwrsav_op_i,
  input  wire logic               irq_pending_i,
  input  wire logic               dev_reset_i,
  input  wire logic               wdt_timeout_i,
  input  wire logic               wdt_enable_i,
  input  wire logic               clock_failure_monitor_enable_i,
  input  wire logic               calendar_clock_enable_i,
  input  wire logic               calendar_clock_low_power_rc_oscillator_src_i,
  input  wire logic               deep_sleep_brownout_reset_enable_i,
  input  wire logic               deep_sleep_brownout_reset_event_i,
  input  wire logic [OSC_W-1:0]   osc_sel_i,
  input  wire psmc_pkg::psmc_wake_t ds_wake_i,
  input  wire logic [PIN_W-1:0]   pin_dir_i,
  input  wire logic [PIN_W-1:0]   pin_lat_i,
  // Power, clock and pin control
  output psmc_pkg::psmc_pwr_t     pwr_o,
  output psmc_pkg::psmc_mode_t    mode_o,
  output logic                    wdt_clear_o,
  output logic                    wake_o,
  output logic                    irq_discard_o,
  output logic                    por_req_o,
  output logic [OSC_W-1:0]        resume_osc_o,
  output logic [PIN_W-1:0]        pin_dir_o,
  output logic [PIN_W-1:0]        pin_lat_o
);

  initial
  begin
    if (PIN_W < 1 || PIN_W > 32 || OSC_W < 1 || OSC_W > 8)
      $error("psmc_top: unsupported PIN_W or OSC_W");
  end

  // ==========================================================
  // Bus decode
  wire logic bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic bus_wr     = bus_req & wb_we_i;
  wire logic sel_ctrl   = (wb_adr_i == psmc_pkg::ADDR_CTRL);
  wire logic sel_wake   = (wb_adr_i == psmc_pkg::ADDR_WAKE);
  wire logic sel_ctxa   = (wb_adr_i == psmc_pkg::ADDR_CTXA);
  wire logic sel_ctxb   = (wb_adr_i == psmc_pkg::ADDR_CTXB);
  wire logic sel_status = (wb_adr_i == psmc_pkg::ADDR_STATUS);
  wire logic wr_ctrl_hi = bus_wr & sel_ctrl & wb_sel_i[1];
  wire logic wr_ctrl_lo = bus_wr & sel_ctrl & wb_sel_i[0];

  // ==========================================================
  // State
  psmc_pkg::psmc_mode_t mode_q;
  psmc_pkg::psmc_mode_t mode_d;
  psmc_pkg::psmc_wake_t wake_q;
  logic                 deep_sleep_enable_bit_q;
  logic                 deep_sleep_enable_bit_d;
  logic                 release_q;
  logic                 bor_q;
  logic                 exited_q;
  logic [1:0]           win_q;
  logic [31:0]          ctxa_q;
  logic [31:0]          ctxb_q;
  logic [OSC_W-1:0]     osc_q;
  logic [PIN_W-1:0]     fdir_q;
  logic [PIN_W-1:0]     flat_q;

  // ==========================================================
  // Mode entry and wake decode
  wire logic in_run   = (mode_q == psmc_pkg::MODE_RUN);
  wire logic enter    = in_run & pwrsav_i;
  wire logic op_sleep = (pwrsav_op_i == psmc_pkg::OP_SLEEP);
  wire logic go_deep  = enter & op_sleep & deep_sleep_enable_bit_q;
  wire logic go_sleep = enter & op_sleep & ~deep_sleep_enable_bit_q;
  wire logic go_idle  = enter & ~op_sleep;
  // wake sources of sleep and idle
  wire logic lite_wk  = irq_pending_i | dev_reset_i | wdt_timeout_i;
  wire logic deep_wk  = |ds_wake_i;
  wire logic in_lite  = (mode_q == psmc_pkg::MODE_SLEEP) |
                        (mode_q == psmc_pkg::MODE_IDLE);
  wire logic in_deep  = (mode_q == psmc_pkg::MODE_DEEP);
  // a coincident interrupt wakes on the cycle after entry
  wire logic wake_lt  = in_lite & lite_wk;
  wire logic wake_dp  = in_deep & deep_wk;
  // window expires on the third instruction cycle
  wire logic win_end  = deep_sleep_enable_bit_q & instr_cycle_i & ~pwrsav_i &
                        (win_q == psmc_pkg::DEEP_SLEEP_ENABLE_BIT_WINDOW - 2'h1);
  wire logic deep_sleep_enable_bit_set = wr_ctrl_hi & wb_dat_i[psmc_pkg::CTRL_DEEP_SLEEP_ENABLE_BIT_BIT];

  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      psmc_pkg::MODE_RUN:
      begin
        if (go_deep)
          mode_d = psmc_pkg::MODE_DEEP;
        else if (go_sleep)
          mode_d = psmc_pkg::MODE_SLEEP;
        else if (go_idle)
          mode_d = psmc_pkg::MODE_IDLE;
      end
      psmc_pkg::MODE_SLEEP,
      psmc_pkg::MODE_IDLE:
      begin
        if (wake_lt)
          mode_d = psmc_pkg::MODE_RUN;
      end
      psmc_pkg::MODE_DEEP:
      begin
        if (wake_dp)
          mode_d = psmc_pkg::MODE_RUN;
      end
      default: mode_d = psmc_pkg::MODE_RUN;
    endcase
  end

  always_comb
  begin
    deep_sleep_enable_bit_d = deep_sleep_enable_bit_q;
    if (win_end)
      deep_sleep_enable_bit_d = 1'b0;
    if (wake_dp)
      deep_sleep_enable_bit_d = 1'b0;
    // software write of the enable bit
    if (wr_ctrl_hi && !in_deep)
      deep_sleep_enable_bit_d = wb_dat_i[psmc_pkg::CTRL_DEEP_SLEEP_ENABLE_BIT_BIT];
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= psmc_pkg::MODE_RUN;
      deep_sleep_enable_bit_q <= 1'b0;
      win_q  <= 2'h0;
    end
    else
    begin
      mode_q <= mode_d;
      deep_sleep_enable_bit_q <= deep_sleep_enable_bit_d;
      win_q  <= (deep_sleep_enable_bit_set || !deep_sleep_enable_bit_q) ? 2'h0 :
                (instr_cycle_i ? win_q + 2'h1 : win_q);
    end
  end

  // Context words and wake status survive deep sleep
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_q   <= '0;
      bor_q    <= 1'b0;
      exited_q <= 1'b0;
      ctxa_q   <= 32'h0000_0000;
      ctxb_q   <= 32'h0000_0000;
    end
    else
    begin
      // setting enable wipes status; capture below wins
      if (deep_sleep_enable_bit_set)
        wake_q <= '0;
      if (wake_dp)
        wake_q <= wake_q | ds_wake_i;
      if (in_deep && deep_sleep_brownout_reset_enable_i && deep_sleep_brownout_reset_event_i)
        bor_q <= 1'b1;
      else if (wr_ctrl_lo && !wb_dat_i[psmc_pkg::CTRL_BOR_BIT])
        bor_q <= 1'b0;
      if (wake_dp)
        exited_q <= 1'b1;
      else if (bus_wr && sel_status && wb_sel_i[0] && wb_dat_i[0])
        exited_q <= 1'b0;
      if (bus_wr && sel_ctxa)
        ctxa_q <= wb_dat_i;
      if (bus_wr && sel_ctxb)
        ctxb_q <= wb_dat_i;
    end
  end

  // ==========================================================
  // Pin freeze and clock source memory
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      release_q <= 1'b0;
      osc_q     <= '0;
      fdir_q    <= '0;
      flat_q    <= '0;
    end
    else
    begin
      // pins held until software clears release
      if (go_deep)
        release_q <= 1'b1;
      else if (wr_ctrl_lo && !wb_dat_i[psmc_pkg::CTRL_RELEASE_BIT])
        release_q <= 1'b0;
      if (go_deep || go_sleep)
      begin
        fdir_q <= pin_dir_i;
        flat_q <= pin_lat_i;
      end
      // remember clock source at sleep, idle or deep sleep entry
      if (enter)
        osc_q <= osc_sel_i;
    end
  end

  wire logic frozen = (mode_q == psmc_pkg::MODE_SLEEP) | in_deep | release_q;

  // ==========================================================
  // Power and clock enables
  psmc_pkg::psmc_pwr_t pwr_d;

  always_comb
  begin
    pwr_d           = '0;
    pwr_d.mem_pwr   = 1'b1;
    // calendar keeps counting in every mode
    pwr_d.calendar_clock_run  = calendar_clock_enable_i;
    case (mode_q)
      psmc_pkg::MODE_RUN:
      begin
        pwr_d.sys_clk    = 1'b1;
        pwr_d.osc        = 1'b1;
        pwr_d.cpu_clk    = 1'b1;
        pwr_d.periph_clk = 1'b1;
        pwr_d.clock_failure_monitor       = clock_failure_monitor_enable_i;
        pwr_d.low_power_rc_oscillator       = wdt_enable_i | clock_failure_monitor_enable_i |
                           (calendar_clock_enable_i & calendar_clock_low_power_rc_oscillator_src_i);
      end
      psmc_pkg::MODE_SLEEP:
      begin
        // system clock and its peripherals off
        pwr_d.sys_clk = 1'b0;
        pwr_d.clock_failure_monitor    = 1'b0;
        // RC oscillator for watchdog or calendar
        pwr_d.low_power_rc_oscillator    = wdt_enable_i | (calendar_clock_enable_i & calendar_clock_low_power_rc_oscillator_src_i);
      end
      psmc_pkg::MODE_IDLE:
      begin
        pwr_d.sys_clk    = 1'b1;
        pwr_d.osc        = 1'b1;
        pwr_d.periph_clk = 1'b1;
        pwr_d.clock_failure_monitor       = clock_failure_monitor_enable_i;
        // RC oscillator for watchdog or monitor
        pwr_d.low_power_rc_oscillator       = wdt_enable_i | clock_failure_monitor_enable_i |
                           (calendar_clock_enable_i & calendar_clock_low_power_rc_oscillator_src_i);
      end
      psmc_pkg::MODE_DEEP:
      begin
        // memory power removed, only calendar, watchdog and enabled brown-out
        pwr_d.mem_pwr   = 1'b0;
        pwr_d.low_power_rc_oscillator      = calendar_clock_enable_i & calendar_clock_low_power_rc_oscillator_src_i;
        pwr_d.deep_sleep_watchdog_run = 1'b1;
        pwr_d.deep_sleep_brownout_reset_run = deep_sleep_brownout_reset_enable_i;
      end
      default: pwr_d = '0;
    endcase
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_o         <= '0;
      mode_o        <= psmc_pkg::MODE_RUN;
      wdt_clear_o   <= 1'b0;
      wake_o        <= 1'b0;
      irq_discard_o <= 1'b0;
      por_req_o     <= 1'b0;
      resume_osc_o  <= '0;
      pin_dir_o     <= '0;
      pin_lat_o     <= '0;
    end
    else
    begin
      pwr_o         <= pwr_d;
      mode_o        <= mode_q;
      wdt_clear_o   <= wdt_enable_i & (go_sleep | go_idle);
      // wake pulse restarts CPU clock at once
      wake_o        <= wake_lt;
      // pending interrupts dropped at deep entry
      irq_discard_o <= go_deep;
      // deep wake forces a full power-on reset
      por_req_o     <= wake_dp;
      resume_osc_o  <= osc_q;
      pin_dir_o     <= frozen ? fdir_q : pin_dir_i;
      pin_lat_o     <= frozen ? flat_q : pin_lat_i;
    end
  end

  // ==========================================================
  // Read mux, one wait state, unmapped reads return zero
  logic [31:0] rd_d;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (sel_ctrl)
    begin
      rd_d[psmc_pkg::CTRL_DEEP_SLEEP_ENABLE_BIT_BIT]    = deep_sleep_enable_bit_q;
      rd_d[psmc_pkg::CTRL_BOR_BIT]     = bor_q;
      rd_d[psmc_pkg::CTRL_RELEASE_BIT] = release_q;
    end
    else if (sel_wake)
      rd_d[psmc_pkg::WAKE_W-1:0] = wake_q;
    else if (sel_ctxa)
      rd_d = ctxa_q;
    else if (sel_ctxb)
      rd_d = ctxb_q;
    else if (sel_status)
    begin
      rd_d[0]   = exited_q;
      rd_d[2:1] = mode_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_d : 32'h0000_0000;
    end
  end

endmodule : psmc_top

//--- tb/psmc_assertions.sv
// Port-level checks of the power save mode controller
`timescale 1ns/100ps
module psmc_assertions #(
  parameter int PIN_W = 16,
  parameter int OSC_W = 3
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 pwrsav_i,
  input wire logic [7:0]           pwrsav_op_i,
  input wire logic                 irq_pending_i,
  input wire logic                 dev_reset_i,
  input wire logic                 wdt_timeout_i,
  input wire logic                 wdt_enable_i,
  input wire logic                 clock_failure_monitor_enable_i,
  input wire logic                 calendar_clock_enable_i,
  input wire logic                 calendar_clock_low_power_rc_oscillator_src_i,
  input wire logic [OSC_W-1:0]     osc_sel_i,
  input wire psmc_pkg::psmc_wake_t ds_wake_i,
  input wire psmc_pkg::psmc_pwr_t  pwr_o,
  input wire psmc_pkg::psmc_mode_t mode_o,
  input wire logic                 wdt_clear_o,
  input wire logic                 wake_o,
  input wire logic                 irq_discard_o,
  input wire logic                 por_req_o,
  input wire logic [OSC_W-1:0]     resume_osc_o,
  input wire logic [PIN_W-1:0]     pin_dir_o,
  input wire logic [PIN_W-1:0]     pin_lat_o
);
  // ==========================================================
  // Mode decode
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire run = mode_o == psmc_pkg::MODE_RUN;
  wire slp = mode_o == psmc_pkg::MODE_SLEEP;
  wire idl = mode_o == psmc_pkg::MODE_IDLE;
  wire dep = mode_o == psmc_pkg::MODE_DEEP;

  // ==========================================================
  // Properties
  property p_idle_entry;
    pwrsav_i && !$past(pwrsav_i) && run && (pwrsav_op_i != psmc_pkg::OP_SLEEP)
      |-> ##2 idl && pwr_o.periph_clk && !pwr_o.cpu_clk;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");
  property p_sleep_pwr;
    slp |-> !pwr_o.sys_clk && !pwr_o.osc && !pwr_o.cpu_clk && !pwr_o.periph_clk
      && !pwr_o.clock_failure_monitor && (!$past(wdt_enable_i || calendar_clock_enable_i && calendar_clock_low_power_rc_oscillator_src_i) || pwr_o.low_power_rc_oscillator);
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("sleep enables wrong");
  property p_idle_pwr;
    idl |-> pwr_o.sys_clk && pwr_o.periph_clk && !pwr_o.cpu_clk
      && (!$past(wdt_enable_i || clock_failure_monitor_enable_i) || pwr_o.low_power_rc_oscillator);
  endproperty
  a_idle_pwr: assert property (p_idle_pwr) else $error("idle enables wrong");
  property p_wake;
    (slp || idl) && (irq_pending_i || dev_reset_i || wdt_timeout_i) |-> ##[0:2] wake_o ##1 run;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep or idle");
  property p_wdt_clear;
    (slp || idl) && $past(run) && $past(wdt_enable_i, 2) |-> $past(wdt_clear_o);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");
  property p_osc;
    slp && $past(run) |-> resume_osc_o == $past(osc_sel_i, 2);
  endproperty
  a_osc: assert property (p_osc) else $error("clock source not kept");
  property p_deep_pwr;
    dep |-> !pwr_o.sys_clk && !pwr_o.cpu_clk && !pwr_o.periph_clk && !pwr_o.mem_pwr
      && pwr_o.deep_sleep_watchdog_run && (!$past(calendar_clock_enable_i) || pwr_o.calendar_clock_run);
  endproperty
  a_deep_pwr: assert property (p_deep_pwr) else $error("deep enables wrong");
  property p_deep_wake;
    dep && (|ds_wake_i) |-> ##[0:2] por_req_o;
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("no reset on deep wake");
  property p_pins;
    (slp || dep) && $past(slp || dep) |-> $stable(pin_dir_o) && $stable(pin_lat_o);
  endproperty
  a_pins: assert property (p_pins) else $error("pins moved while frozen");
  property p_discard;
    dep && $past(run) && $past(irq_pending_i, 2) |-> $past(irq_discard_o);
  endproperty
  a_discard: assert property (p_discard) else $error("pending interrupt kept");

  // ==========================================================
  // Scenario coverage
  c_sleep: cover property (slp && wake_o);
  c_idle: cover property (idl && wake_o);
  c_deep: cover property (dep && por_req_o);
endmodule : psmc_assertions

//--- tb/psmc_core_model.sv
// Core model: instruction cycle strobe and system clock source select
`timescale 1ns/100ps
module psmc_core_model #(
  parameter int OSC_W = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             halt_i,
  input  wire logic             wake_i,
  output logic                  instr_cycle_o,
  output logic      [OSC_W-1:0] osc_sel_o
);
  logic [1:0] phase_q;
  // ==========================================================
  // Four clocks per instruction; a halted core issues none
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phase_q   <= 2'h0;
      osc_sel_o <= '0;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
      // Software switches source after each sleep or idle wake, so entry sees a new one
      if (wake_i)
        osc_sel_o <= osc_sel_o + 1'b1;
    end
  end
  assign instr_cycle_o = (phase_q == 2'h3) && !halt_i;
endmodule : psmc_core_model

//--- tb/power_save_mode_controller_tb.sv
// Self-checking bench of the power save mode controller
`timescale 1ns/100ps
module power_save_mode_controller_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, pwrsav_op_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, instr_cycle_i, pwrsav_i = 1'b0, irq_pending_i = 1'b0, dev_reset_i = 1'b0;
  logic wdt_timeout_i = 1'b0, wdt_enable_i = 1'b1, clock_failure_monitor_enable_i = 1'b0, calendar_clock_enable_i = 1'b0;
  logic calendar_clock_low_power_rc_oscillator_src_i = 1'b0, deep_sleep_brownout_reset_enable_i = 1'b1, deep_sleep_brownout_reset_event_i = 1'b0;
  logic [2:0] osc_sel_i, resume_osc_o;
  psmc_pkg::psmc_wake_t ds_wake_i = '0;
  logic [15:0] pin_dir_i = 16'h0, pin_lat_i = 16'h0, pin_dir_o, pin_lat_o, pins;
  psmc_pkg::psmc_pwr_t pwr_o;
  psmc_pkg::psmc_mode_t mode_o;
  logic wdt_clear_o, wake_o, irq_discard_o, por_req_o;
  int failures = 0;
  int tests_run = 0;

  always #50 clk_i = ~clk_i;

  psmc_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_cycle_i, .pwrsav_i, .pwrsav_op_i, .irq_pending_i,
    .dev_reset_i, .wdt_timeout_i, .wdt_enable_i, .clock_failure_monitor_enable_i, .calendar_clock_enable_i,
    .calendar_clock_low_power_rc_oscillator_src_i, .deep_sleep_brownout_reset_enable_i, .deep_sleep_brownout_reset_event_i, .osc_sel_i, .ds_wake_i, .pin_dir_i,
    .pin_lat_i, .pwr_o, .mode_o, .wdt_clear_o, .wake_o, .irq_discard_o, .por_req_o,
    .resume_osc_o, .pin_dir_o, .pin_lat_o);

  psmc_core_model core_u (.clk_i, .rst_i, .halt_i(mode_o != psmc_pkg::MODE_RUN),
    .wake_i(wake_o), .instr_cycle_o(instr_cycle_i), .osc_sel_o(osc_sel_i));

  // ==========================================================
  // Tasks
  task automatic finish_test;
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (wb_ack_o !== 1'b1)
    begin
      failures++;
      finish_test();
    end
  endtask : wb

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic psave(input logic [7:0] op);
    @(posedge clk_i);
    {pwrsav_i, pwrsav_op_i} <= {1'b1, op};
    @(posedge clk_i);
    pwrsav_i <= 1'b0;
    tick(1);
  endtask : psave

  task automatic wait_run;
    int n;
    for (n = 0; mode_o !== psmc_pkg::MODE_RUN && n < 50; n++)
      tick(1);
    if (n >= 50)
    begin
      failures++;
      finish_test();
    end
    @(posedge clk_i);
    {irq_pending_i, dev_reset_i, wdt_timeout_i} <= 3'h0;
  endtask : wait_run

  function automatic psmc_pkg::psmc_mode_t exp_mode(input logic [7:0] op);
    return (op == psmc_pkg::OP_SLEEP) ? psmc_pkg::MODE_SLEEP : psmc_pkg::MODE_IDLE;
  endfunction : exp_mode

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [7:0] op;
    logic [31:0] ctx;
    void'($urandom(32'hE90D));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      op = (i % 2 == 0) ? psmc_pkg::OP_SLEEP : 8'($urandom_range(255, 1));
      @(posedge clk_i);
      {wdt_enable_i, clock_failure_monitor_enable_i, calendar_clock_enable_i, calendar_clock_low_power_rc_oscillator_src_i} <= 4'($urandom);
      irq_pending_i <= (i % 4 == 3);
      psave(op);
      chk("mode_o", 32'(exp_mode(op)), 32'(mode_o));
      if (i % 4 == 3)
      begin
        tick(1);
        chk("mode_o", 32'(psmc_pkg::MODE_RUN), 32'(mode_o));
      end
      tick($urandom_range(6, 1));
      @(posedge clk_i);
      {pin_dir_i, pin_lat_i} <= 32'($urandom);
      {dev_reset_i, wdt_timeout_i, irq_pending_i} <= 3'h1 << (i % 3);
      wait_run();
    end
    wb(1'b1, 8'h14, 4'hF, 32'hFFFF_FFFF);
    wb(1'b0, 8'h14, 4'hF, 32'h0);
    chk("unmapped read", 32'h0, rd);
    for (int k = 0; k < 5; k++)
    begin
      ctx = $urandom;
      wb(1'b1, psmc_pkg::ADDR_CTXA, 4'hF, ctx);
      @(posedge clk_i);
      irq_pending_i <= 1'b1;
      wb(1'b1, psmc_pkg::ADDR_CTRL, 4'h2, 32'h8000);
      wb(1'b0, psmc_pkg::ADDR_WAKE, 4'hF, 32'h0);
      chk("wake status", 32'h0, rd);
      psave(psmc_pkg::OP_SLEEP);
      chk("mode_o", 32'(psmc_pkg::MODE_DEEP), 32'(mode_o));
      pins = pin_dir_o;
      @(posedge clk_i);
      {pin_dir_i, irq_pending_i} <= {~pin_dir_i, 1'b0};
      ds_wake_i <= psmc_pkg::psmc_wake_t'(5'h1 << k);
      deep_sleep_brownout_reset_event_i <= (k == 2);
      @(posedge clk_i);
      ds_wake_i <= '0;
      deep_sleep_brownout_reset_event_i <= 1'b0;
      wait_run();
      wb(1'b0, psmc_pkg::ADDR_WAKE, 4'hF, 32'h0);
      chk("wake status", 32'h1 << k, rd);
      wb(1'b0, psmc_pkg::ADDR_CTRL, 4'hF, 32'h0);
      chk("enable bit", 32'h0, 32'(rd[15]));
      chk("brown-out flag", 32'(k == 2), 32'(rd[1]));
      chk("release bit", 32'h1, 32'(rd[0]));
      wb(1'b0, psmc_pkg::ADDR_STATUS, 4'hF, 32'h0);
      chk("exit flag", 32'h1, rd);
      wb(1'b1, psmc_pkg::ADDR_STATUS, 4'h1, 32'h1);
      chk("frozen pins", 32'(pins), 32'(pin_dir_o));
      wb(1'b1, psmc_pkg::ADDR_CTRL, 4'h1, 32'h0);
      tick(2);
      chk("released pins", 32'(pin_dir_i), 32'(pin_dir_o));
      wb(1'b0, psmc_pkg::ADDR_CTXA, 4'hF, 32'h0);
      chk("context word", ctx, rd);
      tick(12);
    end
    wb(1'b1, psmc_pkg::ADDR_CTRL, 4'h2, 32'h8000);
    tick(16);
    wb(1'b0, psmc_pkg::ADDR_CTRL, 4'hF, 32'h0);
    chk("enable bit", 32'h0, 32'(rd[15]));
    psave(psmc_pkg::OP_SLEEP);
    chk("mode_o", 32'(psmc_pkg::MODE_SLEEP), 32'(mode_o));
    @(posedge clk_i);
    wdt_timeout_i <= 1'b1;
    wait_run();
    finish_test();
  end
endmodule : power_save_mode_controller_tb

bind psmc_top psmc_assertions #(.PIN_W(PIN_W), .OSC_W(OSC_W)) chk_u (.clk_i, .rst_i,
  .pwrsav_i, .pwrsav_op_i, .irq_pending_i, .dev_reset_i, .wdt_timeout_i, .wdt_enable_i,
  .clock_failure_monitor_enable_i, .calendar_clock_enable_i, .calendar_clock_low_power_rc_oscillator_src_i, .osc_sel_i, .ds_wake_i, .pwr_o, .mode_o,
  .wdt_clear_o, .wake_o, .irq_discard_o, .por_req_o, .resume_osc_o, .pin_dir_o, .pin_lat_o);
